// File: core/isx_line_mon.sv
/*
 * Line monitor: two-flop synchronisers on both bus pins, then edge,
 * start and stop detection. Assumes pins are asynchronous to clk_i.
 */
`timescale 1ns/1ns
module isx_line_mon
	import isx_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Raw pins
	input  wire logic scl_i,
	input  wire logic sda_i,
	// Line events
	isx_line_if.mon   ln
);

	logic [2:0] scl_q;       // Sync pair plus history stage
	logic [2:0] sda_q;
	logic [2:0] next_scl_q;
	logic [2:0] next_sda_q;

	// Shift the pins in; stage 0 is only read by stage 1
	always_comb
	begin
		next_scl_q = {scl_q[1:0], scl_i};
		next_sda_q = {sda_q[1:0], sda_i};
	end

	// Idle bus reads high
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end
		else
		begin
			scl_q <= next_scl_q;
			sda_q <= next_sda_q;
		end
	end

	// Data moving while clock stays high marks start or stop
	assign ln.scl_lvl  = scl_q[1];
	assign ln.sda_lvl  = sda_q[1];
	assign ln.scl_rise = scl_q[1] & ~scl_q[2];
	assign ln.scl_fall = ~scl_q[1] & scl_q[2];
	assign ln.start    = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
	assign ln.stop     = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

endmodule : isx_line_mon

// File: core/isx_slave_tx.sv
/*
 * Slave engine: address match, address acknowledge and byte transmit
 * with transmit-ready event timing. Assumes synchronous reset that is
 * also raised while the module is held in reset or in pin mode.
 */
`timescale 1ns/1ns
module isx_slave_tx
	import isx_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	isx_line_if.eng         ln,
	input  wire logic [6:0] own_addr_i,  // Own slave address
	input  wire logic [7:0] tx_data_i,   // Transmit buffer word
	input  wire logic       tsel_i,      // Ready timing select
	output logic            sda_low_o,   // Pull data pin low
	output logic            evt_tx_o,    // Transmit-ready pulse
	output logic            evt_adr_o,   // Address matched pulse
	output logic            rw_o         // Read bit of last match
);

	isx_state_t st, next_st;
	logic [7:0] sh, next_sh;       // Transmit shift register
	logic [2:0] cnt, next_cnt;     // Bit counter
	logic       ack_ok, next_ack_ok;
	logic       next_sda_low, next_evt_tx, next_evt_adr, next_rw;

	// Next-state logic; stop and start override every state
	always_comb
	begin
		next_st = st; next_sh = sh; next_cnt = cnt; next_ack_ok = ack_ok;
		next_sda_low = sda_low_o; next_rw = rw_o;
		next_evt_tx = 1'b0; next_evt_adr = 1'b0;
		if (ln.stop) begin next_st = ST_IDLE; next_sda_low = 1'b0; end
		else if (ln.start)
		begin
			next_st = ST_ADDR; next_cnt = 3'h0; next_sda_low = 1'b0;
		end
		else
			case (st)
			ST_IDLE: ;
			ST_ADDR: if (ln.scl_rise)
			begin
				next_sh = {sh[6:0], ln.sda_lvl};
				next_cnt = cnt + 3'h1;
				if (cnt == CNT_LAST)
				begin
					if (sh[6:0] == own_addr_i)
					begin
						next_st = ST_AACK; next_rw = ln.sda_lvl;
						next_evt_adr = 1'b1;
						next_evt_tx = ln.sda_lvl;
					end
					else next_st = ST_IDLE;
				end
			end
			ST_AACK: if (ln.scl_fall) begin next_sda_low = 1'b1; next_st = ST_AHOLD; end
			ST_AHOLD: if (ln.scl_fall)
			begin
				next_sda_low = rw_o & ~tx_data_i[7]; next_sh = tx_data_i; next_cnt = 3'h0;
				next_st = rw_o ? ST_TXB : ST_IDLE;
			end
			ST_TXB: if (ln.scl_fall)
			begin
				next_cnt = cnt + 3'h1;
				next_sh = {sh[6:0], 1'b0};
				next_sda_low = (cnt == CNT_LAST) ? 1'b0 : ~sh[6];
				if (cnt == CNT_LAST) next_st = ST_TXA;
			end
			ST_TXA:
			begin
				// Timing select acts only in the slave transmit states
				if (ln.scl_rise)
				begin
					next_ack_ok = ~ln.sda_lvl;
					next_evt_tx = ~ln.sda_lvl & ~tsel_i;
				end
				if (ln.scl_fall && ack_ok)
				begin
					next_sh = tx_data_i; next_cnt = 3'h0;
					next_sda_low = ~tx_data_i[7]; next_st = ST_TXB;
					next_evt_tx = tsel_i;
				end
				else if (ln.scl_fall) next_st = ST_IDLE;
			end
			default: next_st = ST_IDLE;
			endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st <= ST_IDLE; sh <= 8'h00; cnt <= 3'h0; ack_ok <= 1'b0;
			sda_low_o <= 1'b0; evt_tx_o <= 1'b0; evt_adr_o <= 1'b0; rw_o <= 1'b0;
		end
		else
		begin
			st <= next_st; sh <= next_sh; cnt <= next_cnt; ack_ok <= next_ack_ok;
			sda_low_o <= next_sda_low; evt_tx_o <= next_evt_tx;
			evt_adr_o <= next_evt_adr; rw_o <= next_rw;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_mode0_ack_evt: assert property ((st == ST_TXA && ln.scl_rise && !ln.sda_lvl && !tsel_i
		&& !ln.start && !ln.stop) |=> evt_tx_o) else $error("no ready on master ack");
	chk_mode1_copy_evt: assert property ((st == ST_TXA && ln.scl_fall && ack_ok && tsel_i
		&& !ln.start && !ln.stop) |=> evt_tx_o && st == ST_TXB) else $error("no ready on copy");
	chk_nack_ends_tx: assert property ((st == ST_TXA && ln.scl_fall && !ack_ok)
		|=> st == ST_IDLE) else $error("send after nack");

endmodule : isx_slave_tx

// File: core/isx_top.sv
/*
 * Slave transmit extension top: Wishbone register slave, status and
 * interrupt logic, pin-function switch and the line monitor and
 * engine instances. Assumes classic Wishbone on clk_i and open-drain
 * pins with external pull-ups.
 */
// The implementer's own choices: the Wishbone register port and the register addresses.
// Function
// - Read to own address enters slave transmit
// - First ready event on address match with read
// - Timing one: later events at buffer copy
// - Keep copying while master keeps acknowledging
// - Timing zero: later events at master acknowledge
// - Timing select matters only in slave transmit
// - Interrupt gated by enable, DMA event not
// - Both pins usable as general-purpose I/O
// - Addressed-as-slave and stop interrupts, each maskable
// - Direction and stop-seen flags in status
// - Direction flag set in transmit, clears variously
// - Stop flag sets on any bus stop outside pin mode
// - Timing select at bit zero, resets one
// - Pin mode one: pins are general I/O
`timescale 1ns/1ns
module isx_top
	import isx_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Serial clock pin
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	// Serial data pin
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	// Events
	output logic             irq_o,
	output logic             tx_dma_evt_o
);

	// ****************************************
	// Declarations
	// ****************************************
	isx_line_if ln ();                     // Line events

	logic        sda_low;                  // Engine pulls data low
	logic        evt_tx;                   // Transmit-ready pulse
	logic        evt_adr;                  // Address matched pulse
	logic        rw_dir;                   // Read bit of last match
	logic        eng_rst;                  // Engine held in reset

	logic        req;                      // Bus cycle active
	logic        wr;                       // Write commits this edge
	logic [31:0] wd;                       // Write data after byte lanes
	logic [31:0] w1c;                      // Status clear mask
	logic [31:0] str_word;                 // Status read image
	logic [31:0] rdata;                    // Read mux
	logic        irq_pend;                 // Any enabled flag set

	logic [6:0]  own_slave_addr_reg, next_oar;
	logic [6:0]  irq_enable_reg, next_ier;
	logic [7:0]  tx_buffer_reg, next_dxr;
	logic        module_reset_release, next_irs;
	logic        loopback, next_dlb;
	logic        tx_ready_timing_sel, next_tsel;
	logic        pin_gpio_enable, next_gpm;
	logic [1:0]  pin_direction_reg, next_pdir;
	logic [1:0]  pin_output_reg, next_pdout;
	logic        str_xrdy, next_xrdy;      // Transmit ready flag
	logic        str_scd, next_scd;        // Stop seen flag
	logic        str_aas, next_aas;        // Addressed-as-slave flag
	logic        slave_tx_direction_flag, next_slave_tx_direction_flag;

	logic [31:0] next_dat;
	logic        next_ack;
	logic        next_irq, next_dma;
	logic        next_scl_o, next_scl_oe, next_sda_o, next_sda_oe;

	// ****************************************
	// Submodules
	// ****************************************
	isx_line_mon u_mon (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.scl_i (scl_i),
		.sda_i (sda_i),
		.ln    (ln)
	);

	// Engine idles while held in reset, in pin mode or in loopback
	assign eng_rst = rst_i | ~module_reset_release | pin_gpio_enable | loopback;

	isx_slave_tx u_eng (
		.clk_i      (clk_i),
		.rst_i      (eng_rst),
		.ln         (ln),
		.own_addr_i (own_slave_addr_reg),
		.tx_data_i  (tx_buffer_reg),
		.tsel_i     (tx_ready_timing_sel),
		.sda_low_o  (sda_low),
		.evt_tx_o   (evt_tx),
		.evt_adr_o  (evt_adr),
		.rw_o       (rw_dir)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	// Writes commit at the edge where the master sees ack
	assign req = wb_cyc_i & wb_stb_i;
	assign wr  = req & wb_we_i & wb_ack_o;
	assign wd  = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign w1c = (wr && wb_adr_i == OFS_STR) ? wd : 32'h0;

	// Status image; unlisted bits read zero
	always_comb
	begin
		str_word = 32'h0;
		str_word[BIT_XRDY] = str_xrdy;
		str_word[BIT_SCD]  = str_scd;
		str_word[BIT_AAS]  = str_aas;
		str_word[BIT_SLAVE_TX_DIRECTION_FLAG] = slave_tx_direction_flag;
	end

	// Read mux
	always_comb
	begin
		rdata = 32'h0;
		case (wb_adr_i)
		OFS_OAR:   rdata = {25'h0, own_slave_addr_reg};
		OFS_IER:   rdata = {25'h0, irq_enable_reg};
		OFS_STR:   rdata = str_word;
		OFS_DXR:   rdata = {24'h0, tx_buffer_reg};
		OFS_MDR:   rdata = {25'h0, loopback, module_reset_release, 5'h00};
		OFS_EMDR:  rdata = {31'h0, tx_ready_timing_sel};
		OFS_PFUNC: rdata = {31'h0, pin_gpio_enable};
		OFS_PDIR:  rdata = {30'h0, pin_direction_reg};
		OFS_PDIN:  rdata = {30'h0, ln.sda_lvl, ln.scl_lvl};
		OFS_PDOUT: rdata = {30'h0, pin_output_reg};
		OFS_PDSET: rdata = {30'h0, pin_output_reg};
		OFS_PDCLR: rdata = {30'h0, pin_output_reg};
		default:   rdata = 32'h0;
		endcase
	end

	// ****************************************
	// Bus answer
	// ****************************************
	// One wait cycle, ack for one cycle, unmapped reads zero
	always_comb
	begin
		next_ack = req & ~wb_ack_o;
		next_dat = next_ack ? rdata : wb_dat_o;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// ****************************************
	// Control and status registers
	// ****************************************
	always_comb
	begin
		next_oar   = own_slave_addr_reg;
		next_ier   = irq_enable_reg;
		next_dxr   = tx_buffer_reg;
		next_irs   = module_reset_release;
		next_dlb   = loopback;
		next_tsel  = tx_ready_timing_sel;
		next_gpm   = pin_gpio_enable;
		next_pdir  = pin_direction_reg;
		next_pdout = pin_output_reg;
		if (wr)
		begin
			case (wb_adr_i)
			OFS_OAR:   next_oar = wd[6:0];
			OFS_IER:   next_ier = wd[6:0] & IER_WMASK;
			OFS_DXR:   next_dxr = wd[7:0];
			OFS_MDR:
			begin
				next_irs = wd[BIT_IRS];
				next_dlb = wd[BIT_DLB];
			end
			OFS_EMDR:  next_tsel = wd[0];
			OFS_PFUNC: next_gpm = wd[0];
			OFS_PDIR:  next_pdir = wd[1:0];
			OFS_PDOUT: next_pdout = wd[1:0];
			OFS_PDSET: next_pdout = pin_output_reg | wd[1:0];
			OFS_PDCLR: next_pdout = pin_output_reg & ~wd[1:0];
			default:   next_oar = own_slave_addr_reg;
			endcase
		end
		// Sticky flags: a set in the clearing cycle wins
		next_xrdy = (str_xrdy & ~(w1c[BIT_XRDY] | (wr && wb_adr_i == OFS_DXR)))
			| evt_tx;
		next_scd  = (str_scd & ~w1c[BIT_SCD]) | (ln.stop & ~pin_gpio_enable);
		next_aas  = (str_aas & ~w1c[BIT_AAS]) | evt_adr;
		// Loopback forces the direction flag low
		next_slave_tx_direction_flag = ((slave_tx_direction_flag
			& ~(w1c[BIT_SLAVE_TX_DIRECTION_FLAG] | ln.start | ln.stop)) | (evt_adr & rw_dir))
			& ~loopback;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			own_slave_addr_reg      <= RST_OAR;
			irq_enable_reg          <= 7'h00;
			tx_buffer_reg           <= 8'h00;
			module_reset_release    <= 1'b0;
			loopback                <= 1'b0;
			tx_ready_timing_sel     <= RST_TSEL;
			pin_gpio_enable         <= RST_GPM;
			pin_direction_reg       <= 2'h0;
			pin_output_reg          <= 2'h0;
			str_xrdy                <= RST_XRDY;
			str_scd                 <= 1'b0;
			str_aas                 <= 1'b0;
			slave_tx_direction_flag <= 1'b0;
		end
		else
		begin
			own_slave_addr_reg      <= next_oar;
			irq_enable_reg          <= next_ier;
			tx_buffer_reg           <= next_dxr;
			module_reset_release    <= next_irs;
			loopback                <= next_dlb;
			tx_ready_timing_sel     <= next_tsel;
			pin_gpio_enable         <= next_gpm;
			pin_direction_reg       <= next_pdir;
			pin_output_reg          <= next_pdout;
			str_xrdy                <= next_xrdy;
			str_scd                 <= next_scd;
			str_aas                 <= next_aas;
			slave_tx_direction_flag <= next_slave_tx_direction_flag;
		end
	end

	// ****************************************
	// Interrupt, DMA event and pins
	// ****************************************
	// Each source reaches the line only when enabled
	assign irq_pend = (str_xrdy & irq_enable_reg[BIT_XRDY])
		| (str_scd & irq_enable_reg[BIT_SCD])
		| (str_aas & irq_enable_reg[BIT_AASI]);

	always_comb
	begin
		next_irq = irq_pend;
		next_dma = evt_tx;
		if (pin_gpio_enable)
		begin
			// Pin mode: direction and output registers own the pins
			next_scl_oe = pin_direction_reg[PIN_SCL];
			next_scl_o  = pin_output_reg[PIN_SCL];
			next_sda_oe = pin_direction_reg[PIN_SDA];
			next_sda_o  = pin_output_reg[PIN_SDA];
		end
		else
		begin
			// Bus mode: only the data pin is pulled low
			next_scl_oe = 1'b0;
			next_scl_o  = 1'b0;
			next_sda_oe = sda_low;
			next_sda_o  = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_o        <= 1'b0;
			tx_dma_evt_o <= 1'b0;
			scl_o        <= 1'b0;
			scl_oe_o     <= 1'b0;
			sda_o        <= 1'b0;
			sda_oe_o     <= 1'b0;
		end
		else
		begin
			irq_o        <= next_irq;
			tx_dma_evt_o <= next_dma;
			scl_o        <= next_scl_o;
			scl_oe_o     <= next_scl_oe;
			sda_o        <= next_sda_o;
			sda_oe_o     <= next_sda_oe;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_slave_tx_direction_flag_on_read: assert property ((evt_adr && rw_dir && !loopback && !ln.start)
		|=> slave_tx_direction_flag) else $error("direction not set on read");
	chk_slave_tx_direction_flag_stop_clr: assert property ((ln.stop && !evt_adr)
		|=> !slave_tx_direction_flag) else $error("direction kept after stop");
	chk_scd_on_stop: assert property ((ln.stop && !pin_gpio_enable)
		|=> str_scd) else $error("stop flag missed");
	chk_tsel_reset: assert property ($fell(rst_i)
		|-> tx_ready_timing_sel && !pin_gpio_enable) else $error("bad reset value");
	chk_gpio_pins: assert property (pin_gpio_enable && $stable(pin_direction_reg)
		|=> scl_oe_o == $past(pin_direction_reg[PIN_SCL])
		&& sda_oe_o == $past(pin_direction_reg[PIN_SDA])) else $error("pin mode ignored");
	chk_aas_irq: assert property ((evt_adr && irq_enable_reg[BIT_AASI])
		|=> ##1 irq_o) else $error("slave address irq missing");
	chk_irq_gated: assert property ((irq_enable_reg == 7'h00 && $stable(irq_enable_reg))
		|=> !irq_o) else $error("irq while all masked");
	chk_dma_event: assert property (evt_tx |=> tx_dma_evt_o ##1 !tx_dma_evt_o)
		else $error("dma event wrong");
	chk_read_first: assert property ((evt_adr && rw_dir) |-> evt_tx)
		else $error("no ready at read address");
	chk_bus_ack: assert property ((req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");

	cov_ready_copy:  cover property (evt_tx && tx_ready_timing_sel && !evt_adr);
	cov_ready_ack:   cover property (evt_tx && !tx_ready_timing_sel && !evt_adr);
	cov_stop_seen:   cover property (ln.stop && slave_tx_direction_flag);
	cov_pin_mode:    cover property (pin_gpio_enable && scl_oe_o);

endmodule : isx_top

// File: inc/isx_line_if.sv
/*
 * Synchronised serial-bus line events passed from the line monitor
 * to the engine and the register block. Assumes one clock domain.
 */
`timescale 1ns/1ns
interface isx_line_if;
	logic scl_lvl;   // Synchronised clock pin level
	logic sda_lvl;   // Synchronised data pin level
	logic scl_rise;  // Clock pin rose
	logic scl_fall;  // Clock pin fell
	logic start;     // Start or repeated start seen
	logic stop;      // Stop seen
	modport mon (output scl_lvl, sda_lvl, scl_rise, scl_fall, start, stop);
	modport eng (input scl_lvl, sda_lvl, scl_rise, scl_fall, start, stop);
endinterface : isx_line_if

// File: inc/isx_pkg.sv
/*
 * Constants shared by the slave-transmit extension: register offsets,
 * field positions, reset values and the engine state type.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package isx_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_OAR   = 8'h00;
	localparam logic [7:0] OFS_IER   = 8'h04;
	localparam logic [7:0] OFS_STR   = 8'h08;
	localparam logic [7:0] OFS_DXR   = 8'h20;
	localparam logic [7:0] OFS_MDR   = 8'h24;
	localparam logic [7:0] OFS_EMDR  = 8'h2c;
	localparam logic [7:0] OFS_PFUNC = 8'h48;
	localparam logic [7:0] OFS_PDIR  = 8'h4c;
	localparam logic [7:0] OFS_PDIN  = 8'h50;
	localparam logic [7:0] OFS_PDOUT = 8'h54;
	localparam logic [7:0] OFS_PDSET = 8'h58;
	localparam logic [7:0] OFS_PDCLR = 8'h5c;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_XRDY = 4;   // Transmit ready (status and enable)
	localparam int BIT_SCD  = 5;   // Stop seen (status and enable)
	localparam int BIT_AASI = 6;   // Addressed-as-slave enable
	localparam int BIT_AAS  = 9;   // Addressed-as-slave status
	localparam int BIT_SLAVE_TX_DIRECTION_FLAG = 14;  // Slave transmit direction
	localparam int BIT_IRS  = 5;   // Module reset release
	localparam int BIT_DLB  = 6;   // Digital loopback
	localparam int PIN_SCL  = 0;   // Pin register lane of the clock pin
	localparam int PIN_SDA  = 1;   // Pin register lane of the data pin
	localparam logic [6:0] IER_WMASK = 7'h70;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic       RST_TSEL = 1'b1;
	localparam logic       RST_GPM  = 1'b0;
	localparam logic       RST_XRDY = 1'b1;
	localparam logic [6:0] RST_OAR  = 7'h00;
	localparam logic [2:0] CNT_LAST = 3'h7;

	// Engine states
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_AHOLD, ST_TXB, ST_TXA
	} isx_state_t;

endpackage : isx_pkg

// File: test/isx_i2c_master.sv
/* Serial bus master model: start, address, reads, ack, stop.
   Assumes the bench resolves the wired lines with pull-ups. */
`timescale 1ns/1ns
module isx_i2c_master
(
	// Clock and resolved data line
	input  wire logic clk_i,
	input  wire logic sda_i,
	// Line drives, one means released
	output logic      scl_o,
	output logic      sda_o
);
	// ****
	// Bit level
	// ****
	// Lines idle released, clock stands still between frames
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Wait whole clock cycles
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// Hold both lines at a level, for pin tests
	task automatic drive(input logic c, input logic d);
		scl_o <= c;
		sda_o <= d;
	endtask : drive
	// One 48 ns slot; clock rises only once the slave's bit has settled,
	// since the slave moves its data about four cycles after each fall
	task automatic slot(input logic b, output logic s);
		tick(1);
		sda_o <= b;
		tick(4);
		scl_o <= 1'b1;
		tick(4);
		s = sda_i;
		tick(3);
		scl_o <= 1'b0;
	endtask : slot
	// Frame: n bytes read, nack on the last, then stop
	task automatic xfer(input logic [6:0] a, input logic rw, input int n,
		output logic ack, output logic [7:0] q[$]);
		logic       s;
		logic [7:0] b;
		q = {};
		sda_o <= 1'b0;
		tick(6);
		scl_o <= 1'b0;
		// Address MSB first, then direction
		for (int i = 7; i >= 0; i--)
			slot(i > 0 ? a[i-1] : rw, s);
		slot(1'b1, s);
		ack = !s;
		for (int k = 0; k < n && ack && rw; k++)
		begin
			for (int i = 0; i < 8; i++)
			begin
				slot(1'b1, s);
				b = {b[6:0], s};
			end
			q.push_back(b);
			slot(k == n - 1, s);
		end
		tick(1);
		sda_o <= 1'b0;
		tick(2);
		scl_o <= 1'b1;
		tick(6);
		sda_o <= 1'b1;
		tick(12);
	endtask : xfer
endmodule : isx_i2c_master

// File: test/tb_isx_top.sv
/* Bench: bus tasks, a queue model of sent bytes, flag and pin checks.
   Assumes the design package and the bus master model. */
`timescale 1ns/1ns
module tb_isx_top
	import isx_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, rv;
	logic        ack, scl_o, scl_oe, sda_o, sda_oe, irq, dma, m_scl, m_sda;
	logic [6:0]  own;
	int          num_errors = 0, n_checks = 0, n_evt = 0;
	// Wired lines with pull-ups
	wire logic   scl_w = m_scl & (scl_oe ? scl_o : 1'b1);
	wire logic   sda_w = m_sda & (sda_oe ? sda_o : 1'b1);

	isx_top dut_u
	(
		.clk_i        (clk),
		.rst_i        (rst),
		.wb_cyc_i     (cyc),
		.wb_stb_i     (stb),
		.wb_we_i      (we),
		.wb_adr_i     (adr),
		.wb_sel_i     (sel),
		.wb_dat_i     (wdat),
		.wb_dat_o     (rdat),
		.wb_ack_o     (ack),
		.scl_i        (scl_w),
		.scl_o        (scl_o),
		.scl_oe_o     (scl_oe),
		.sda_i        (sda_w),
		.sda_o        (sda_o),
		.sda_oe_o     (sda_oe),
		.irq_o        (irq),
		.tx_dma_evt_o (dma)
	);
	isx_i2c_master m_u
	(
		.clk_i (clk),
		.sda_i (sda_w),
		.scl_o (m_scl),
		.sda_o (m_sda)
	);

	// 250 MHz clock
	initial
	begin
		forever #2 clk = ~clk;
	end
	// Count ready events
	always @(posedge clk)
		if (dma === 1'b1)
			n_evt <= n_evt + 1;

	task automatic stop_test;
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	// Bounded wait for ack (0) or ready event (1)
	task automatic wait_for(input int w);
		int t;
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while ((w ? dma : ack) !== 1'b1 && t < 500);
		if (t >= 500)
		begin
			num_errors++;
			stop_test;
		end
	endtask : wait_for
	// Classic single cycle; data taken at the ack edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		wdat <= d;
		wait_for(0);
		rv = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(rv & m, e);
	endtask : rd
	// Read n bytes; a new word is fed on every ready event
	task automatic run(input logic ts, input int n);
		logic [7:0] w[$];
		logic [7:0] q[$];
		logic       ok;
		int         e0;
		e0 = n_evt;
		fork
			m_u.xfer(own, 1'b1, n, ok, q);
			repeat (n)
			begin
				wait_for(1);
				w.push_back(8'($urandom));
				wb(1'b1, OFS_DXR, {24'h0, w[$]});
				if (w.size() == 1)
					rd(OFS_STR, 32'h4200, 32'h4200);
			end
		join
		check({31'h0, ok}, 32'h1);
		check(n_evt - e0, n);
		check(q.size(), n);
		foreach (q[k])
			check({24'h0, q[k]}, {24'h0, ts ? w[k > 0 ? k - 1 : 0] : w[k]});
		rd(OFS_STR, 32'h4230, 32'h220);
		check({31'h0, irq}, 32'h1);
		wb(1'b1, OFS_STR, 32'h4230);
	endtask : run

	// ****
	// Main sequence
	// ****
	initial
	begin
		logic       ok;
		logic [7:0] q[$];
		logic [1:0] d;
		void'($urandom(32'hbe56));
		own = 7'($urandom);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_EMDR, 32'hffffffff, 32'h1);
		rd(OFS_PFUNC, 32'h1, 32'h0);
		rd(OFS_STR, 32'h4230, 32'h10);
		rd(8'h60, 32'hffffffff, 32'h0);
		wb(1'b1, OFS_OAR, {25'h0, own});
		wb(1'b1, OFS_MDR, 32'h20);
		wb(1'b1, OFS_IER, 32'h70);
		run(1'b1, 3);
		wb(1'b1, OFS_EMDR, 32'h0);
		run(1'b0, 4);
		// Wrong address, then a write: no ready events
		m_u.xfer(own ^ 7'h01, 1'b1, 1, ok, q);
		check({31'h0, ok}, 32'h0);
		m_u.xfer(own, 1'b0, 0, ok, q);
		check(n_evt, 32'd7);
		rd(OFS_STR, 32'h4030, 32'h20);
		// Mask, unmask, clear
		wb(1'b1, OFS_IER, 32'h0);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		wb(1'b1, OFS_IER, 32'h20);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		wb(1'b1, OFS_STR, 32'h20);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		// Pin mode, entered from module reset
		wb(1'b1, OFS_MDR, 32'h0);
		wb(1'b1, OFS_PFUNC, 32'h1);
		wb(1'b1, OFS_PDIR, 32'h3);
		repeat (4)
		begin
			d = 2'($urandom);
			wb(1'b1, OFS_PDOUT, {30'h0, d});
			repeat (3) @(posedge clk);
			check({28'h0, sda_oe, scl_oe, sda_o, scl_o}, {28'h0, 2'b11, d});
		end
		wb(1'b1, OFS_PDSET, 32'h1);
		wb(1'b1, OFS_PDCLR, 32'h2);
		rd(OFS_PDOUT, 32'h3, 32'h1);
		wb(1'b1, OFS_PDIR, 32'h0);
		d = 2'($urandom);
		m_u.drive(d[0], d[1]);
		repeat (4) @(posedge clk);
		rd(OFS_PDIN, 32'h3, {30'h0, d});
		stop_test;
	end
endmodule : tb_isx_top
